// >>> inc/bcwr_map.vh
`ifndef BCWR_MAP_VH
`define BCWR_MAP_VH
// ****************************************
// bus states
// ****************************************
`define BCWR_ST_IDLE  3'h0
`define BCWR_ST_ONE   3'h1
`define BCWR_ST_TWO   3'h2
`define BCWR_ST_THREE 3'h3
`define BCWR_ST_WAIT  3'h4
`define BCWR_ST_FOUR  3'h5
// ****************************************
// reset values
// ****************************************
`define BCWR_READY_RST 1'b0
`define BCWR_SYNC_RST  2'h0
`define BCWR_EN_SYNC_RST 2'h3
`define BCWR_FLAG_RST    1'h0
`endif

// >>> logic/bcwr_ready_sync.v
`timescale 1ns/1ps
`default_nettype none
`include "bcwr_map.vh"
// ****************************************
// ready synchronizer
// ****************************************
module bcwr_ready_sync (
  input  wire sys_clk,
  input  wire rst_b,
  input  wire ready_source_a,
  input  wire ready_source_b,
  input  wire ready_source_a_enable_n,
  input  wire ready_source_b_enable_n,
  output reg  ready_q
);
  reg  [1:0] rdy_sync_q;
  reg  [1:0] en_n_sync_q;
  reg  [1:0] rdy_meta_q;
  reg  [1:0] en_n_meta_q;
  wire       ready_d;

  // pins cross into the clock domain through two flops before gating
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdy_meta_q  <= `BCWR_SYNC_RST;
      rdy_sync_q  <= `BCWR_SYNC_RST;
      // enables come up disabled so nothing looks ready before the pins cross
      en_n_meta_q <= `BCWR_EN_SYNC_RST;
      en_n_sync_q <= `BCWR_EN_SYNC_RST;
    end else begin
      rdy_meta_q  <= {ready_source_b, ready_source_a};
      rdy_sync_q  <= rdy_meta_q;
      en_n_meta_q <= {ready_source_b_enable_n, ready_source_a_enable_n};
      en_n_sync_q <= en_n_meta_q;
    end
  end

  assign ready_d = (rdy_sync_q[0] & ~en_n_sync_q[0]) |
                   (rdy_sync_q[1] & ~en_n_sync_q[1]);

  // one register per clock: output holds for the whole period
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_q <= `BCWR_READY_RST;
    end else begin
      ready_q <= ready_d;
    end
  end
endmodule
`default_nettype wire

// >>> logic/bcwr_bus_cycle.v
// Operation
// - ready inactive when sampled inserts wait states until active
// - two ready inputs, each qualified by its own active-low enable
// - gated readies ORed and registered every clock
// - synchronized ready changes only at clock edge, holds whole period
// - wait states sit between three and four: four clocks plus one per wait
`timescale 1ns/1ps
`default_nettype none
`include "bcwr_map.vh"
module bcwr_bus_cycle (
  input  wire       sys_clk,
  input  wire       rst_b,
  input  wire       cycle_request,
  input  wire       ready_source_a,
  input  wire       ready_source_b,
  input  wire       ready_source_a_enable_n,
  input  wire       ready_source_b_enable_n,
  output reg  [2:0] bus_state_q,
  output reg        wait_state_q,
  output reg        cycle_done_q,
  output reg        ready_out_q
);
  // ****************************************
  // state codes
  // ****************************************
  localparam [2:0] ST_IDLE  = `BCWR_ST_IDLE;
  localparam [2:0] ST_ONE   = `BCWR_ST_ONE;
  localparam [2:0] ST_TWO   = `BCWR_ST_TWO;
  localparam [2:0] ST_THREE = `BCWR_ST_THREE;
  localparam [2:0] ST_WAIT  = `BCWR_ST_WAIT;
  localparam [2:0] ST_FOUR  = `BCWR_ST_FOUR;

  // ****************************************
  // reset values
  // ****************************************
  localparam [2:0] STATE_RST = `BCWR_ST_IDLE;
  localparam       FLAG_RST  = `BCWR_FLAG_RST;
  localparam       READY_RST = `BCWR_READY_RST;

  // ****************************************
  // ready path
  // ****************************************
  wire ready_sync;

  bcwr_ready_sync u_sync (
    .sys_clk                 (sys_clk),
    .rst_b                   (rst_b),
    .ready_source_a          (ready_source_a),
    .ready_source_b          (ready_source_b),
    .ready_source_a_enable_n (ready_source_a_enable_n),
    .ready_source_b_enable_n (ready_source_b_enable_n),
    .ready_q                 (ready_sync)
  );

  // ****************************************
  // request synchronizer
  // ****************************************
  reg req_meta_q;
  reg req_sync_q;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      req_meta_q <= 1'b0;
      req_sync_q <= 1'b0;
    end else begin
      req_meta_q <= cycle_request;
      req_sync_q <= req_meta_q;
    end
  end

  // ****************************************
  // state decode
  // ****************************************
  wire in_idle;
  wire in_three;
  wire in_wait;
  wire in_four;
  wire at_sample_point;
  wire may_start;
  wire ready_taken;

  assign in_idle         = (bus_state_q == ST_IDLE);
  assign in_three        = (bus_state_q == ST_THREE);
  assign in_wait         = (bus_state_q == ST_WAIT);
  assign in_four         = (bus_state_q == ST_FOUR);
  // ready counts only at the edges that leave three or a wait state
  assign at_sample_point = in_three | in_wait;
  // a new cycle may begin from idle or straight out of four
  assign may_start       = (in_idle | in_four) & req_sync_q;
  // ready is judged after the synchronizer, so a device must lower its pin
  // about three clocks ahead of the sample it wants to stretch
  assign ready_taken     = at_sample_point & ready_sync;

  // ****************************************
  // bus state machine
  // ****************************************
  reg [2:0] state_d;

  // ready is sampled only in three and wait; elsewhere it is ignored, so a
  // late-falling ready in a normally-ready system would end the cycle early
  always @* begin
    state_d = bus_state_q;
    case (bus_state_q)
      ST_IDLE: begin
        if (may_start) begin
          state_d = ST_ONE;
        end
      end
      ST_ONE: begin
        state_d = ST_TWO;
      end
      ST_TWO: begin
        state_d = ST_THREE;
      end
      ST_THREE: begin
        if (ready_taken) begin
          state_d = ST_FOUR;
        end else begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        // no limit on waits: a device that never answers holds the bus
        if (ready_taken) begin
          state_d = ST_FOUR;
        end else begin
          state_d = ST_WAIT;
        end
      end
      ST_FOUR: begin
        if (may_start) begin
          state_d = ST_ONE;
        end else begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // ****************************************
  // state register
  // ****************************************
  // idle after reset: no cycle runs until a request has crossed the synchronizer
  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_state_q <= STATE_RST;
    end else begin
      bus_state_q <= state_d;
    end
  end

  // ****************************************
  // status flags
  // ****************************************
  // flags are decoded from the next state so that they line up with
  // bus_state_q instead of trailing it by a clock
  wire wait_state_d;
  wire cycle_done_d;

  assign wait_state_d = (state_d == ST_WAIT);
  assign cycle_done_d = (state_d == ST_FOUR);

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wait_state_q <= FLAG_RST;
    end else begin
      wait_state_q <= wait_state_d;
    end
  end

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      cycle_done_q <= FLAG_RST;
    end else begin
      cycle_done_q <= cycle_done_d;
    end
  end

  // ****************************************
  // ready output
  // ****************************************
  // one more register stage keeps the output straight from a flop; it
  // lags the value the state machine judged by one clock
  wire ready_out_d;

  assign ready_out_d = ready_sync;

  always @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ready_out_q <= READY_RST;
    end else begin
      ready_out_q <= ready_out_d;
    end
  end
endmodule
`default_nettype wire

// >>> verification/bcwr_monitor.sv
`timescale 1ns/1ps
`default_nettype none
module bcwr_monitor (
  input wire logic       sys_clk,
  input wire logic       rst_b,
  input wire logic       ready_source_a,
  input wire logic       ready_source_b,
  input wire logic       ready_source_a_enable_n,
  input wire logic       ready_source_b_enable_n,
  input wire logic [2:0] bus_state_q,
  input wire logic       wait_state_q,
  input wire logic       cycle_done_q,
  input wire logic       ready_out_q
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  wire logic ga = ready_source_a & ~ready_source_a_enable_n;
  wire logic g = ga | (ready_source_b & ~ready_source_b_enable_n);
  wire logic off = ready_source_a_enable_n & ready_source_b_enable_n;
  wire logic [2:0] s = bus_state_q;
  // pins must stay put long enough to cross the synchronizer
  property p_rdy; (rst_b && $stable(g))[*6] |-> ready_out_q == g; endproperty
  a_rdy: assert property (p_rdy) else $error("bad ready");
  property p_off; (rst_b && off)[*6] |-> !ready_out_q; endproperty
  a_off: assert property (p_off) else $error("bad gate");
  property p_dec; s == 3'h3 || s == 3'h4 |=> s == (ready_out_q ? 3'h5 : 3'h4); endproperty
  a_dec: assert property (p_dec) else $error("bad decision");
  property p_seq; s == 3'h1 |=> s == 3'h2 ##1 s == 3'h3; endproperty
  a_seq: assert property (p_seq) else $error("bad order");
  property p_wait; wait_state_q == (s == 3'h4); endproperty
  a_wait: assert property (p_wait) else $error("bad wait");
  property p_done; cycle_done_q |-> s == 3'h5 ##1 !cycle_done_q; endproperty
  a_done: assert property (p_done) else $error("bad done");
  cover property (s == 3'h4 ##1 s == 3'h5);
  cover property (s == 3'h3 ##1 s == 3'h5);
  cover property ($rose(ready_out_q));
endmodule
bind bcwr_bus_cycle bcwr_monitor mon (.sys_clk, .rst_b, .ready_source_a, .ready_source_b,
  .ready_source_a_enable_n, .ready_source_b_enable_n, .bus_state_q, .wait_state_q,
  .cycle_done_q, .ready_out_q);
`default_nettype wire

// >>> verification/bcwr_dev.sv
`timescale 1ns/1ps
`default_nettype none
module bcwr_dev (
  input  wire logic       sys_clk,
  input  wire logic [2:0] st,
  input  wire logic [3:0] lat,
  output var  logic       rdy
);
  logic [3:0] n = 4'h0;
  initial rdy = 1'b0;
  // with lat above zero, ready drops one clock after four is left (also when cycles run back to back), never inside three; with lat zero it stays high
  always @(posedge sys_clk) begin
    n <= (st == 3'h0 || st == 3'h5) ? 4'h0 : n + 4'h1;
    rdy <= n >= lat;
  end
endmodule
`default_nettype wire

// >>> verification/testbench.sv
`timescale 1ns/1ps
`default_nettype none
module testbench;
  logic sys_clk, rst_b, req, ra, rb, ea, eb, ws, cd, ro;
  logic [3:0] lat;
  logic [2:0] st;
  int mismatches, n_checks, len, w, k;
  bcwr_bus_cycle uut (.sys_clk(sys_clk), .rst_b(rst_b), .cycle_request(req),
    .ready_source_a(ra), .ready_source_b(rb), .ready_source_a_enable_n(ea),
    .ready_source_b_enable_n(eb), .bus_state_q(st), .wait_state_q(ws),
    .cycle_done_q(cd), .ready_out_q(ro));
  bcwr_dev dev (.sys_clk(sys_clk), .st(st), .lat(lat), .rdy(ra));
  task give_verdict;
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  task chk(string nm, int e, int g);
    n_checks++;
    if (e !== g) begin
      $display("BAD %s exp %0d got %0d", nm, e, g);
      mismatches++;
    end
  endtask
  task cyc;
    len = 0; w = 0; k = 0;
    do begin
      @(negedge sys_clk);
      len += st !== 3'h0;
      w += ws === 1'b1;
      k++;
    end while (st !== 3'h5 && k < 60);
    if (st !== 3'h5) begin
      $display("BAD cycle_end exp 5 got %0d", st);
      mismatches++;
      give_verdict;
    end
  endtask
  task s_fast;
    @(posedge sys_clk) req <= 1;
    cyc;
    chk("len", 4, len);
    cyc;
    chk("len2", 4, len);
    @(posedge sys_clk) req <= 0;
    repeat (12) @(posedge sys_clk);
  endtask
  task s_slow;
    @(posedge sys_clk) begin lat <= 4'h9; req <= 1; end
    cyc;
    chk("waits", 1, w > 0);
    // nine counts of device latency plus two clocks of pin crossing
    chk("nwait", 11, w);
    chk("lenw", 4 + w, len);
    @(posedge sys_clk) begin lat <= 4'h0; req <= 0; end
    repeat (12) @(posedge sys_clk);
  endtask
  task s_one;
    @(posedge sys_clk) begin
      ea <= 1'h1;
      eb <= 1'h1;
      rb <= 1'h1;
      req <= 1'h1;
    end
    // enable lands one clock too late for the sample in three: one wait
    repeat (3) @(posedge sys_clk);
    eb <= 1'h0;
    cyc;
    chk("len_one", 5, len);
    chk("waits_one", 1, w);
    @(posedge sys_clk) begin
      eb <= 1'h1;
      req <= 1'h0;
    end
    repeat (12) @(posedge sys_clk);
  endtask
  task s_sel;
    @(posedge sys_clk) begin ea <= 1; rb <= 1; req <= 1; end
    repeat (14) @(negedge sys_clk);
    chk("held", 1, st === 3'h4);
    chk("rdy_off", 1, ro === 1'b0);
    @(posedge sys_clk) begin eb <= 0; req <= 0; end
    for (k = 0; k < 12 && cd !== 1'b1; k++) @(negedge sys_clk);
    chk("done", 1, cd === 1'b1);
    chk("rdy_on", 1, ro === 1'b1);
  endtask
  initial begin
    sys_clk = 0;
    forever #2.5 sys_clk = ~sys_clk;
  end
  initial begin
    rst_b = 0; req = 0; rb = 0; ea = 0; eb = 1; lat = 0;
    mismatches = 0; n_checks = 0;
    repeat (12) @(posedge sys_clk);
    rst_b <= 1;
    s_fast;
    s_slow;
    s_one;
    s_sel;
    give_verdict;
  end
endmodule
`default_nettype wire
